// [shared/eight_bit_core_execution_consts.svh]
// Constants for the 8-bit core execution unit
`ifndef EIGHT_BIT_CORE_EXECUTION_CONSTS_SVH
`define EIGHT_BIT_CORE_EXECUTION_CONSTS_SVH

// Status byte bit positions
`define FLAG_CARRY 3'd0
`define FLAG_ZERO 3'd1
`define FLAG_NEGATIVE 3'd2
`define FLAG_OVERFLOW 3'd3
`define FLAG_SIGN 3'd4
`define FLAG_HALF 3'd5
`define FLAG_TRANSFER 3'd6
`define FLAG_INTERRUPT 3'd7

// Reset values and the all-ones byte mask
`define STATUS_RESET 8'h00
`define PC_RESET 16'h0000
`define ALL_ONES_BYTE 8'hff

// Cycle counts per operation class
`define CYCLES_SINGLE 2'd1
`define CYCLES_WORD 2'd2
`define CYCLES_POINTER_JUMP 2'd2
`define CYCLES_POINTER_CALL 2'd3
`define CYCLES_PORT_BIT 2'd2
`define CYCLES_POINTER_LOAD 2'd2
`define CYCLES_BRANCH_TAKEN 2'd2
`define CYCLES_SKIP_ONE 2'd2
`define CYCLES_SKIP_TWO 2'd3

// Program counter advance figures, in program words
`define PC_STEP 16'h0001
`define PC_SKIP_ONE 16'h0002
`define PC_SKIP_TWO 16'h0003

`endif

// [shared/eight_bit_core_execution_pkg.sv]
// Types shared by the 8-bit core execution unit and its bench
package eight_bit_core_execution_pkg;

   typedef enum logic [5:0] {
      OP_NONE,
      OP_ADD,
      OP_ADD_CARRY,
      OP_SUB,
      OP_DIFFERENCE_CONSTANT,
      OP_DIFFERENCE_WITH_BORROW,
      OP_CONSTANT_DIFFERENCE_BORROW,
      OP_WORD_IMMEDIATE_SUM,
      OP_WORD_IMMEDIATE_DIFFERENCE,
      OP_AND,
      OP_MASK_CONSTANT,
      OP_OR,
      OP_EXCLUSIVE_OR_REGISTERS,
      OP_MASK_CLEAR_BITS,
      OP_ZERO_SIGN_TEST,
      OP_COMPARE,
      OP_IMMEDIATE_COMPARE,
      OP_POINTER_JUMP,
      OP_POINTER_SUBROUTINE_CALL,
      OP_EQUAL_SKIP_COMPARE,
      OP_SKIP_REG_BIT_LOW,
      OP_SKIP_REG_BIT_HIGH,
      OP_SKIP_PORT_BIT_LOW,
      OP_SKIP_PORT_BIT_HIGH,
      OP_BRANCH_FLAG_HIGH,
      OP_BRANCH_FLAG_LOW,
      OP_BRANCH_SIGNED_NOT_LESS,
      OP_BRANCH_SIGNED_LESS,
      OP_PORT_BIT_SET,
      OP_PORT_BIT_CLEAR,
      OP_ROTATE_LEFT_CARRY,
      OP_TRANSFER_FLAG_STORE,
      OP_TRANSFER_FLAG_LOAD,
      OP_POINTER_LOAD_POST_INC,
      OP_POINTER_LOAD_PRE_DEC
   } op_t;

   typedef enum logic [1:0] {
      PHASE_IDLE,
      PHASE_WAIT,
      PHASE_LOAD
   } phase_t;

   typedef struct packed {
      logic [7:0] result;
      logic carry;
      logic zero;
      logic negative;
      logic overflow;
      logic half;
   } byte_arith_t;

   typedef struct packed {
      logic [15:0] result;
      logic carry;
      logic zero;
      logic negative;
      logic overflow;
   } word_arith_t;

endpackage : eight_bit_core_execution_pkg

// [verilog/eight_bit_core_execution.sv]
// Execution unit of an 8-bit core: ALU, word ops, skips, branches, port bits, pointer loads
//
// Behaviour
// - Add two registers, optionally with carry; flags Z C N V H; one clock.
// - Add constant to register pair, write pair back; flags Z C N V S; two clocks.
// - Subtract constant and carry from register; flags Z C N V H; one clock.
// - Subtract constant from register pair; flags Z C N V S; two clocks.
// - AND, OR, exclusive-OR with register or constant; flags Z N V only; one clock.
// - Clear bits by ANDing with all-ones minus constant; flags Z N V; one clock.
// - Test register by ANDing with itself, value kept; flags Z N V; one clock.
// - Jump to address in Z pointer, no flags changed, two clocks.
// - Call via Z pointer, push return address, no flags changed, three clocks.
// - Skip next instruction when registers equal; PC plus 2 or 3; 1/2/3 clocks.
// - Compare register with immediate, difference not stored; flags Z N V C H.
// - Skip when register bit cleared, or set for other form; 1/2/3 clocks.
// - Skip when port bit set, or cleared for other form; 1/2/3 clocks, no flags.
// - Branch on chosen status bit set or cleared to PC plus offset plus one.
// - Signed not-less branch taken only when negative xor overflow is zero.
// - Signed less branch taken only when negative xor overflow is one.
// - Set or clear one bit of a port register, no flags, two clocks.
// - Rotate left through carry; old carry to bit 0, bit 7 to carry; Z N V.
// - Copy register bit into transfer flag, or transfer flag into register bit.
// - Post-increment load reads addressed location, then pointer plus one.
// - Pre-decrement load subtracts one from pointer, then reads that location.
`include "eight_bit_core_execution_consts.svh"

module eight_bit_core_execution
   import eight_bit_core_execution_pkg::*;
#(
   parameter int OFFSET_WIDTH = 12
)
(
   input wire logic clk,
   input wire logic reset,
   input wire logic issueValid,
   input wire op_t issueOp,
   input wire logic [7:0] operandD,
   input wire logic [7:0] operandB,
   input wire logic [15:0] pairValue,
   input wire logic [15:0] pointerValue,
   input wire logic [7:0] portValue,
   input wire logic [2:0] bitSelect,
   input wire logic [OFFSET_WIDTH-1:0] jumpOffset,
   input wire logic skippedIsTwoWord,
   input wire logic [7:0] memReadData,
   output logic busy,
   output logic done,
   output logic [15:0] pc,
   output logic [7:0] statusByte,
   output logic [7:0] resultData,
   output logic resultWrite,
   output logic [15:0] pairResult,
   output logic pairWrite,
   output logic [15:0] pointerResult,
   output logic pointerWrite,
   output logic [7:0] portWriteData,
   output logic portWrite,
   output logic [15:0] memAddr,
   output logic memRead,
   output logic [15:0] stackData,
   output logic stackPush
);

   typedef struct packed {
      phase_t phase;
      logic [1:0] waitCount;
      logic busy;
      logic done;
      logic [15:0] pc;
      logic [7:0] statusByte;
      logic [7:0] resultData;
      logic resultWrite;
      logic [15:0] pairResult;
      logic pairWrite;
      logic [15:0] pointerResult;
      logic pointerWrite;
      logic [7:0] portWriteData;
      logic portWrite;
      logic portPending;
      logic [15:0] memAddr;
      logic memRead;
      logic [15:0] stackData;
      logic stackPush;
   } state_t;

   state_t current;
   state_t next_current;

   // Byte add or subtract with carry/borrow in
   function automatic byte_arith_t byteArith(input logic [7:0] a, input logic [7:0] b,
                                              input logic carryIn, input logic subtract);
      byte_arith_t r;
      logic [8:0] wide;
      logic [4:0] low;
      if (subtract)
      begin
         wide = {1'b0, a} - {1'b0, b} - {8'h00, carryIn};
         low = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, carryIn};
         r.overflow = (a[7] & ~b[7] & ~wide[7]) | (~a[7] & b[7] & wide[7]);
      end
      else
      begin
         wide = {1'b0, a} + {1'b0, b} + {8'h00, carryIn};
         low = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, carryIn};
         r.overflow = (a[7] & b[7] & ~wide[7]) | (~a[7] & ~b[7] & wide[7]);
      end
      r.result = wide[7:0];
      r.carry = wide[8];
      r.half = low[4];
      r.zero = (wide[7:0] == 8'h00);
      r.negative = wide[7];
      return r;
   endfunction : byteArith

   // Word add or subtract of a constant on a register pair
   function automatic word_arith_t wordArith(input logic [15:0] a, input logic [7:0] k,
                                              input logic subtract);
      word_arith_t r;
      logic [16:0] wide;
      if (subtract)
      begin
         wide = {1'b0, a} - {9'h000, k};
         r.overflow = a[15] & ~wide[15];
      end
      else
      begin
         wide = {1'b0, a} + {9'h000, k};
         r.overflow = ~a[15] & wide[15];
      end
      r.result = wide[15:0];
      r.carry = wide[16];
      r.zero = (wide[15:0] == 16'h0000);
      r.negative = wide[15];
      return r;
   endfunction : wordArith

   // Flags of a logic result: overflow always cleared
   function automatic logic [7:0] logicFlags(input logic [7:0] s, input logic [7:0] value);
      logic [7:0] f;
      f = s;
      f[`FLAG_ZERO] = (value == 8'h00);
      f[`FLAG_NEGATIVE] = value[7];
      f[`FLAG_OVERFLOW] = 1'b0;
      return f;
   endfunction : logicFlags

   function automatic logic [7:0] arithFlags(input logic [7:0] s, input byte_arith_t a);
      logic [7:0] f;
      f = s;
      f[`FLAG_CARRY] = a.carry;
      f[`FLAG_ZERO] = a.zero;
      f[`FLAG_NEGATIVE] = a.negative;
      f[`FLAG_OVERFLOW] = a.overflow;
      f[`FLAG_HALF] = a.half;
      return f;
   endfunction : arithFlags

   function automatic logic [15:0] relativeTarget(input logic [15:0] base,
                                                  input logic [OFFSET_WIDTH-1:0] offset);
      logic [15:0] extended;
      extended = 16'(signed'(offset));
      return base + extended + `PC_STEP;
   endfunction : relativeTarget

   byte_arith_t sum;
   byte_arith_t diff;
   word_arith_t wordOut;
   logic carryNow;
   logic skipCond;
   logic isSkip;
   logic branchCond;
   logic isBranch;
   logic [7:0] logicVal;
   logic [7:0] rotated;

   assign carryNow = current.statusByte[`FLAG_CARRY];

   always_comb
   begin
      next_current = current;
      next_current.done = 1'b0;
      next_current.resultWrite = 1'b0;
      next_current.pairWrite = 1'b0;
      next_current.pointerWrite = 1'b0;
      next_current.portWrite = 1'b0;
      next_current.memRead = 1'b0;
      next_current.stackPush = 1'b0;
      sum = byteArith(operandD, operandB,
         (issueOp == OP_ADD_CARRY) & carryNow, 1'b0);
      diff = byteArith(operandD, operandB,
         (issueOp == OP_DIFFERENCE_WITH_BORROW || issueOp == OP_CONSTANT_DIFFERENCE_BORROW)
         & carryNow, 1'b1);
      wordOut = wordArith(pairValue, operandB, issueOp == OP_WORD_IMMEDIATE_DIFFERENCE);
      case (issueOp)
         OP_OR: logicVal = operandD | operandB;
         OP_EXCLUSIVE_OR_REGISTERS: logicVal = operandD ^ operandB;
         OP_MASK_CLEAR_BITS: logicVal = operandD & (`ALL_ONES_BYTE - operandB);
         OP_ZERO_SIGN_TEST: logicVal = operandD & operandD;
         default: logicVal = operandD & operandB;
      endcase
      rotated = {operandD[6:0], carryNow};
      skipCond = 1'b0;
      isSkip = 1'b1;
      case (issueOp)
         OP_EQUAL_SKIP_COMPARE: skipCond = (operandD == operandB);
         OP_SKIP_REG_BIT_LOW: skipCond = ~operandD[bitSelect];
         OP_SKIP_REG_BIT_HIGH: skipCond = operandD[bitSelect];
         OP_SKIP_PORT_BIT_LOW: skipCond = ~portValue[bitSelect];
         OP_SKIP_PORT_BIT_HIGH: skipCond = portValue[bitSelect];
         default: isSkip = 1'b0;
      endcase
      branchCond = 1'b0;
      isBranch = 1'b1;
      case (issueOp)
         OP_BRANCH_FLAG_HIGH: branchCond = current.statusByte[bitSelect];
         OP_BRANCH_FLAG_LOW: branchCond = ~current.statusByte[bitSelect];
         OP_BRANCH_SIGNED_NOT_LESS: branchCond = (current.statusByte[`FLAG_NEGATIVE]
            ^ current.statusByte[`FLAG_OVERFLOW]) == 1'b0;
         OP_BRANCH_SIGNED_LESS: branchCond = (current.statusByte[`FLAG_NEGATIVE]
            ^ current.statusByte[`FLAG_OVERFLOW]) == 1'b1;
         default: isBranch = 1'b0;
      endcase

      case (current.phase)
         PHASE_IDLE:
         begin
            if (issueValid)
            begin
               next_current.pc = current.pc + `PC_STEP;
               next_current.done = 1'b1;
               case (issueOp)
                  OP_ADD, OP_ADD_CARRY:
                  begin
                     next_current.resultData = sum.result;
                     next_current.resultWrite = 1'b1;
                     next_current.statusByte = arithFlags(current.statusByte, sum);
                  end
                  OP_SUB, OP_DIFFERENCE_CONSTANT, OP_DIFFERENCE_WITH_BORROW,
                  OP_CONSTANT_DIFFERENCE_BORROW:
                  begin
                     next_current.resultData = diff.result;
                     next_current.resultWrite = 1'b1;
                     next_current.statusByte = arithFlags(current.statusByte, diff);
                  end
                  OP_COMPARE, OP_IMMEDIATE_COMPARE:
                     next_current.statusByte = arithFlags(current.statusByte, diff);
                  OP_WORD_IMMEDIATE_SUM, OP_WORD_IMMEDIATE_DIFFERENCE:
                  begin
                     next_current.pairResult = wordOut.result;
                     next_current.pairWrite = 1'b1;
                     next_current.statusByte[`FLAG_CARRY] = wordOut.carry;
                     next_current.statusByte[`FLAG_ZERO] = wordOut.zero;
                     next_current.statusByte[`FLAG_NEGATIVE] = wordOut.negative;
                     next_current.statusByte[`FLAG_OVERFLOW] = wordOut.overflow;
                     next_current.statusByte[`FLAG_SIGN] = wordOut.negative ^ wordOut.overflow;
                     next_current.waitCount = `CYCLES_WORD - 2'd2;
                  end
                  OP_AND, OP_MASK_CONSTANT, OP_OR, OP_EXCLUSIVE_OR_REGISTERS,
                  OP_MASK_CLEAR_BITS, OP_ZERO_SIGN_TEST:
                  begin
                     next_current.resultData = logicVal;
                     next_current.resultWrite = 1'b1;
                     next_current.statusByte = logicFlags(current.statusByte, logicVal);
                  end
                  OP_ROTATE_LEFT_CARRY:
                  begin
                     next_current.resultData = rotated;
                     next_current.resultWrite = 1'b1;
                     next_current.statusByte = logicFlags(current.statusByte, rotated);
                     next_current.statusByte[`FLAG_CARRY] = operandD[7];
                     next_current.statusByte[`FLAG_OVERFLOW] = rotated[7] ^ operandD[7];
                  end
                  OP_TRANSFER_FLAG_STORE:
                     next_current.statusByte[`FLAG_TRANSFER] = operandD[bitSelect];
                  OP_TRANSFER_FLAG_LOAD:
                  begin
                     next_current.resultData = operandD;
                     next_current.resultData[bitSelect] = current.statusByte[`FLAG_TRANSFER];
                     next_current.resultWrite = 1'b1;
                  end
                  OP_POINTER_JUMP:
                  begin
                     next_current.pc = pointerValue;
                     next_current.waitCount = `CYCLES_POINTER_JUMP - 2'd2;
                  end
                  OP_POINTER_SUBROUTINE_CALL:
                  begin
                     next_current.stackData = current.pc + `PC_STEP;
                     next_current.stackPush = 1'b1;
                     next_current.pc = pointerValue;
                     next_current.waitCount = `CYCLES_POINTER_CALL - 2'd2;
                  end
                  OP_PORT_BIT_SET, OP_PORT_BIT_CLEAR:
                  begin
                     next_current.portWriteData = portValue;
                     next_current.portWriteData[bitSelect] = (issueOp == OP_PORT_BIT_SET);
                     next_current.portPending = 1'b1;
                     next_current.waitCount = `CYCLES_PORT_BIT - 2'd2;
                  end
                  OP_POINTER_LOAD_POST_INC:
                  begin
                     next_current.memAddr = pointerValue;
                     next_current.memRead = 1'b1;
                     next_current.pointerResult = pointerValue + 16'h0001;
                     next_current.pointerWrite = 1'b1;
                  end
                  OP_POINTER_LOAD_PRE_DEC:
                  begin
                     next_current.memAddr = pointerValue - 16'h0001;
                     next_current.memRead = 1'b1;
                     next_current.pointerResult = pointerValue - 16'h0001;
                     next_current.pointerWrite = 1'b1;
                  end
                  default: next_current.done = 1'b1;
               endcase
               if (isSkip && skipCond)
               begin
                  // Two-word skipped instruction costs the third clock
                  next_current.pc = current.pc + (skippedIsTwoWord ? `PC_SKIP_TWO
                     : `PC_SKIP_ONE);
                  next_current.waitCount = (skippedIsTwoWord ? `CYCLES_SKIP_TWO
                     : `CYCLES_SKIP_ONE) - 2'd2;
               end
               if (isBranch && branchCond)
               begin
                  next_current.pc = relativeTarget(current.pc, jumpOffset);
                  next_current.waitCount = `CYCLES_BRANCH_TAKEN - 2'd2;
               end
               // Multi-cycle operations hold busy and report done at the last clock
               if (issueOp == OP_POINTER_LOAD_POST_INC || issueOp == OP_POINTER_LOAD_PRE_DEC)
               begin
                  next_current.done = 1'b0;
                  next_current.busy = 1'b1;
                  next_current.phase = PHASE_LOAD;
               end
               else if (issueOp == OP_WORD_IMMEDIATE_SUM || issueOp == OP_WORD_IMMEDIATE_DIFFERENCE
                  || issueOp == OP_POINTER_JUMP || issueOp == OP_POINTER_SUBROUTINE_CALL
                  || issueOp == OP_PORT_BIT_SET || issueOp == OP_PORT_BIT_CLEAR
                  || (isSkip && skipCond) || (isBranch && branchCond))
               begin
                  next_current.done = 1'b0;
                  next_current.busy = 1'b1;
                  next_current.phase = PHASE_WAIT;
               end
            end
         end
         PHASE_WAIT:
         begin
            next_current.waitCount = current.waitCount - 2'd1;
            if (current.waitCount == 2'd0)
            begin
               next_current.busy = 1'b0;
               next_current.done = 1'b1;
               next_current.portWrite = current.portPending;
               next_current.portPending = 1'b0;
               next_current.phase = PHASE_IDLE;
            end
         end
         PHASE_LOAD:
         begin
            next_current.resultData = memReadData;
            next_current.resultWrite = 1'b1;
            next_current.busy = 1'b0;
            next_current.done = 1'b1;
            next_current.phase = PHASE_IDLE;
         end
         default:
            next_current.phase = PHASE_IDLE;
      endcase
   end

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         current <= '{phase: PHASE_IDLE, waitCount: 2'd0, busy: 1'b0, done: 1'b0,
            pc: `PC_RESET, statusByte: `STATUS_RESET, resultData: 8'h00, resultWrite: 1'b0,
            pairResult: 16'h0000, pairWrite: 1'b0, pointerResult: 16'h0000,
            pointerWrite: 1'b0, portWriteData: 8'h00, portWrite: 1'b0, portPending: 1'b0,
            memAddr: 16'h0000,
            memRead: 1'b0, stackData: 16'h0000, stackPush: 1'b0};
      end
      else
      begin
         current <= next_current;
      end
   end

   assign busy = current.busy;
   assign done = current.done;
   assign pc = current.pc;
   assign statusByte = current.statusByte;
   assign resultData = current.resultData;
   assign resultWrite = current.resultWrite;
   assign pairResult = current.pairResult;
   assign pairWrite = current.pairWrite;
   assign pointerResult = current.pointerResult;
   assign pointerWrite = current.pointerWrite;
   assign portWriteData = current.portWriteData;
   assign portWrite = current.portWrite;
   assign memAddr = current.memAddr;
   assign memRead = current.memRead;
   assign stackData = current.stackData;
   assign stackPush = current.stackPush;

endmodule : eight_bit_core_execution

// [test/eight_bit_core_execution_chk.sv]
// Port-level checks on the execution unit
module eight_bit_core_execution_chk
   import eight_bit_core_execution_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic issueValid,
   input wire op_t issueOp,
   input wire logic [15:0] pointerValue,
   input wire logic [7:0] portValue,
   input wire logic [2:0] bitSelect,
   input wire logic busy,
   input wire logic done,
   input wire logic [15:0] pc,
   input wire logic [7:0] statusByte,
   input wire logic resultWrite,
   input wire logic pairWrite,
   input wire logic [7:0] portWriteData,
   input wire logic portWrite,
   input wire logic [15:0] memAddr,
   input wire logic memRead,
   input wire logic [15:0] stackData,
   input wire logic stackPush
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk);
   endclocking
   default disable iff (reset);
   logic take;
   assign take = issueValid && !busy;
   sequence s_two;
      !done ##1 done;
   endsequence
   a_add_one: assert property (take && issueOp == OP_ADD |=> done && resultWrite)
      else $error("add not done in one clock");
   a_word_sum: assert property (take && issueOp == OP_WORD_IMMEDIATE_SUM |=> pairWrite ##0 s_two)
      else $error("word sum timing");
   a_word_diff: assert property (take && issueOp == OP_WORD_IMMEDIATE_DIFFERENCE |=> s_two)
      else $error("word difference timing");
   a_jump_target: assert property (take && issueOp == OP_POINTER_JUMP
      |=> s_two ##0 pc == $past(pointerValue, 2))
      else $error("pointer jump target");
   a_call_push: assert property (take && issueOp == OP_POINTER_SUBROUTINE_CALL
      |=> stackPush && stackData == $past(pc) + 16'h0001 ##2 done)
      else $error("call push or timing");
   a_port_write: assert property (take && issueOp == OP_PORT_BIT_SET |=> s_two ##0
      (portWrite && portWriteData == ($past(portValue, 2) | (8'h01 << $past(bitSelect, 2)))))
      else $error("port bit set");
   a_load_post: assert property (take && issueOp == OP_POINTER_LOAD_POST_INC
      |=> memRead && memAddr == $past(pointerValue) ##1 done)
      else $error("post increment load");
   a_load_pre: assert property (take && issueOp == OP_POINTER_LOAD_PRE_DEC
      |=> memRead && memAddr == $past(pointerValue) - 16'h0001)
      else $error("pre decrement load");
   a_skip_flags: assert property (take && issueOp inside {OP_SKIP_PORT_BIT_LOW,
      OP_SKIP_PORT_BIT_HIGH} |=> statusByte == $past(statusByte))
      else $error("skip touched flags");
   a_notless_fall: assert property (take && issueOp == OP_BRANCH_SIGNED_NOT_LESS
      && statusByte[2] != statusByte[3] |=> done && pc == $past(pc) + 16'h0001)
      else $error("signed branch taken wrongly");
endmodule : eight_bit_core_execution_chk

// [test/data_memory_model.sv]
// Data memory answering pointer loads
module data_memory_model
(
   input wire logic clk,
   input wire logic memRead,
   input wire logic [15:0] memAddr,
   output logic [7:0] memReadData
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] held = 8'h00;
   // Data holds one cycle past the strobe, then turns over so stale reads show
   always_ff @(posedge clk)
   begin
      held <= memRead ? memAddr[7:0] ^ memAddr[15:8] ^ 8'h3c : ~held;
   end
   assign memReadData = memRead ? memAddr[7:0] ^ memAddr[15:8] ^ 8'h3c : held;
endmodule : data_memory_model

// [test/eight_bit_core_execution_test.sv]
// Self-checking bench for the execution unit
module eight_bit_core_execution_test
   import eight_bit_core_execution_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {op_t o; logic [7:0] d, b; logic [2:0] s; logic [11:0] k;
      logic t; logic [15:0] e;} step_t;
   logic clk = 1'b0, reset = 1'b1, issueValid = 1'b0, skippedIsTwoWord = 1'b0;
   op_t issueOp = OP_NONE;
   logic [7:0] operandD = 8'h00, operandB = 8'h00, portValue = 8'h00;
   logic [15:0] wordIn = 16'h0000, p;
   logic [2:0] bitSelect = 3'h0;
   logic [11:0] jumpOffset = 12'h000;
   logic [7:0] memReadData, statusByte, resultData, portWriteData;
   logic [15:0] pc, pairResult, pointerResult, memAddr, stackData;
   logic busy, done, resultWrite, pairWrite, pointerWrite, portWrite, memRead, stackPush;
   int n_mismatch = 0, cmp_count = 0;
   op_t lo[6] = '{OP_AND, OP_MASK_CONSTANT, OP_OR, OP_EXCLUSIVE_OR_REGISTERS,
      OP_MASK_CLEAR_BITS, OP_ZERO_SIGN_TEST};
   logic [7:0] lb[6] = '{8'h3c, 8'h0f, 8'h3c, 8'h3c, 8'h3c, 8'h00};
   logic [7:0] le[6] = '{8'h30, 8'h00, 8'hfc, 8'hcc, 8'hc0, 8'hf0};
   step_t tab[9] = '{'{OP_BRANCH_SIGNED_LESS, 8'h00, 8'h00, 3'h0, 12'hffd, 1'b0, 16'hfffe},
      '{OP_BRANCH_SIGNED_NOT_LESS, 8'h00, 8'h00, 3'h0, 12'h010, 1'b0, 16'h0001},
      '{OP_BRANCH_FLAG_HIGH, 8'h00, 8'h00, 3'h6, 12'h005, 1'b0, 16'h0006},
      '{OP_BRANCH_FLAG_LOW, 8'h00, 8'h00, 3'h1, 12'h800, 1'b0, 16'hf801},
      '{OP_EQUAL_SKIP_COMPARE, 8'h5a, 8'h5a, 3'h0, 12'h000, 1'b1, 16'h0003},
      '{OP_SKIP_REG_BIT_LOW, 8'hfe, 8'h00, 3'h0, 12'h000, 1'b0, 16'h0002},
      '{OP_SKIP_REG_BIT_HIGH, 8'hfe, 8'h00, 3'h0, 12'h000, 1'b0, 16'h0001},
      '{OP_SKIP_PORT_BIT_HIGH, 8'h08, 8'h00, 3'h3, 12'h000, 1'b1, 16'h0003},
      '{OP_SKIP_PORT_BIT_LOW, 8'h08, 8'h00, 3'h3, 12'h000, 1'b0, 16'h0001}};
   eight_bit_core_execution i_dut (.clk, .reset, .issueValid, .issueOp, .operandD, .operandB,
      .pairValue(wordIn), .pointerValue(wordIn), .portValue, .bitSelect, .jumpOffset,
      .skippedIsTwoWord, .memReadData, .busy, .done, .pc, .statusByte, .resultData,
      .resultWrite, .pairResult, .pairWrite, .pointerResult, .pointerWrite, .portWriteData,
      .portWrite, .memAddr, .memRead, .stackData, .stackPush);
   data_memory_model i_mem (.clk, .memRead, .memAddr, .memReadData);
   initial
   begin
      forever #2 clk = ~clk;
   end
   task automatic check(input logic [23:0] seen, input logic [23:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask : check
   task automatic report_and_stop();
      if (n_mismatch == 0 && cmp_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : report_and_stop
   // Issue one operation, then wait a bounded time for its completion pulse
   task automatic run(input op_t o, input logic [7:0] d = 8'h00, b = 8'h00,
      input logic [15:0] w = 16'h0000, input logic [2:0] s = 3'h0,
      input logic [11:0] k = 12'h000, input logic t = 1'b0);
      int n;
      @(posedge clk);
      issueValid <= 1'b1;
      issueOp <= o;
      operandD <= d;
      portValue <= d;
      operandB <= b;
      wordIn <= w;
      bitSelect <= s;
      jumpOffset <= k;
      skippedIsTwoWord <= t;
      @(posedge clk);
      issueValid <= 1'b0;
      n = 0;
      do
      begin
         @(negedge clk);
         n++;
      end while (done !== 1'b1 && n < 8);
      check(done, 1'b1);
   endtask : run
   initial
   begin
      #20000;
      n_mismatch++;
      report_and_stop();
   end
   initial
   begin
      repeat (10) @(posedge clk);
      reset <= 1'b0;
      run(OP_ADD, 8'h0f, 8'h01);
      check({resultData, statusByte}, 16'h1020);
      run(OP_ADD_CARRY, 8'hff, 8'h01);
      check({resultData, statusByte}, 16'h0023);
      run(OP_CONSTANT_DIFFERENCE_BORROW, 8'h10, 8'h01);
      check({resultData, statusByte}, 16'h0e20);
      run(OP_WORD_IMMEDIATE_SUM, 8'h00, 8'h01, 16'h7fff);
      check({pairResult, statusByte}, 24'h80002c);
      run(OP_WORD_IMMEDIATE_DIFFERENCE, 8'h00, 8'h01, 16'h0000);
      check({pairResult, statusByte}, 24'hffff35);
      for (int i = 0; i < 6; i++)
      begin
         run(lo[i], 8'hf0, lb[i]);
         check({resultData, statusByte}, {le[i], 4'h3, 1'b0, le[i][7], le[i] == 8'h00, 1'b1});
      end
      run(OP_CONSTANT_DIFFERENCE_BORROW, 8'h80, 8'h01);
      check({resultData, statusByte}, 16'h7e38);
      run(OP_IMMEDIATE_COMPARE, 8'h10, 8'h20);
      check({resultData, statusByte}, 16'h7e15);
      run(OP_ROTATE_LEFT_CARRY, 8'h80);
      check({resultData, statusByte}, 16'h0119);
      run(OP_TRANSFER_FLAG_STORE, 8'h04, 8'h00, 16'h0000, 3'h2);
      check(statusByte, 8'h59);
      run(OP_TRANSFER_FLAG_LOAD, 8'h00, 8'h00, 16'h0000, 3'h5);
      check(resultData, 8'h20);
      for (int i = 0; i < 9; i++)
      begin
         p = pc;
         run(tab[i].o, tab[i].d, tab[i].b, 16'h0000, tab[i].s, tab[i].k, tab[i].t);
         check({pc, statusByte}, {p + tab[i].e, 8'h59});
      end
      run(OP_PORT_BIT_SET, 8'h00, 8'h00, 16'h0000, 3'h7);
      check(portWriteData, 8'h80);
      run(OP_PORT_BIT_CLEAR, 8'hff);
      check(portWriteData, 8'hfe);
      run(OP_POINTER_JUMP, 8'h00, 8'h00, 16'h1234);
      check(pc, 16'h1234);
      run(OP_POINTER_SUBROUTINE_CALL, 8'h00, 8'h00, 16'h0abc);
      check({pc, stackData[7:0]}, 24'h0abc35);
      run(OP_POINTER_LOAD_POST_INC, 8'h00, 8'h00, 16'h0102);
      check({resultData, pointerResult}, 24'h3f0103);
      run(OP_POINTER_LOAD_PRE_DEC, 8'h00, 8'h00, 16'h0200);
      check({resultData, pointerResult}, 24'hc201ff);
      report_and_stop();
   end
endmodule : eight_bit_core_execution_test
bind eight_bit_core_execution eight_bit_core_execution_chk i_chk (.clk, .reset, .issueValid,
   .issueOp, .pointerValue, .portValue, .bitSelect, .busy, .done, .pc, .statusByte,
   .resultWrite, .pairWrite, .portWriteData, .portWrite, .memAddr, .memRead, .stackData,
   .stackPush);
